// *** pkg/seeprm_regs.vh ***
// Purpose: Constants for the serial memory command engine.
// Assumes: A 50 MHz system clock.
// Notes: Times are given in their own unit with derived cycle counts.
`ifndef SEEPRM_REGS_VH
`define SEEPRM_REGS_VH
`define SEEPRM_CLK_MHZ 50
`define SEEPRM_OP_READ 2'h1 << 1
`define SEEPRM_OPC_READ 2'h2
`define SEEPRM_OPC_WRITE 2'h1
`define SEEPRM_OPC_ERASE 2'h3
`define SEEPRM_OPC_SPECIAL 2'h0
`define SEEPRM_SUB_ENABLE 2'h3
`define SEEPRM_SUB_DISABLE 2'h0
`define SEEPRM_SUB_ERASE_ALL 2'h2
`define SEEPRM_SUB_WRITE_ALL 2'h1
`define SEEPRM_T_WORD_US 6000
`define SEEPRM_T_ERASE_ALL_US 6000
`define SEEPRM_T_WRITE_ALL_US 15000
`define SEEPRM_ERASED_BIT 1'h1
`define SEEPRM_BUSY_LEVEL 1'h0
`define SEEPRM_READY_LEVEL 1'h1
`endif

// *** hdl/seeprm_engine.v ***
// Purpose: Command engine of a small three-wire serial memory.
// Assumes: Serial clock, select and data come from an outside master.
// Notes: Serial pins are synchronised and edge detected on MCLK.
`include "seeprm_regs.vh"
`default_nettype none
module seeprm_engine #(
  parameter WORD16 = 1,
  parameter AW = (WORD16 != 0) ? 6 : 7,
  parameter DW = (WORD16 != 0) ? 16 : 8,
  parameter T_WORD_CYC = `SEEPRM_T_WORD_US * `SEEPRM_CLK_MHZ,
  parameter T_ERASE_ALL_CMD_CYC = `SEEPRM_T_ERASE_ALL_US * `SEEPRM_CLK_MHZ,
  parameter T_WRITE_ALL_CMD_CYC = `SEEPRM_T_WRITE_ALL_US * `SEEPRM_CLK_MHZ
) (
  input wire MCLK,
  input wire RESETN,
  input wire POWER_GOOD,
  input wire CHIP_SEL,
  input wire SER_CLK,
  input wire SERIAL_IN,
  output reg SERIAL_OUT,
  output reg SERIAL_OUT_OE,
  output reg PROG_BUSY
);
  localparam DEPTH = 1 << AW;
  localparam ST_IDLE = 5'h01;
  localparam ST_CMD = 5'h02;
  localparam ST_DATA = 5'h04;
  localparam ST_READ = 5'h08;
  localparam ST_DONE = 5'h10;
  localparam CMDW = AW + 2;
  localparam [31:0] DW32 = DW;
  localparam [5:0] CNT_DW = DW32[5:0];
  localparam [5:0] CNT_LAST = CNT_DW - 6'h1;
  localparam PS_IDLE = 3'h1;
  localparam PS_ERASE = 3'h2;
  localparam PS_PROG = 3'h4;

  reg [DW-1:0] mem [0:DEPTH-1];
  reg [2:0] cs_s_r, ck_s_r, di_s_r;
  reg pg1_r, pg2_r;
  reg [4:0] st_r;
  reg [CMDW-1:0] cmd_r;
  reg [5:0] cnt_r;
  reg [DW-1:0] sh_r;
  reg [AW-1:0] addr_r;
  reg wen_r;
  reg pend_r;
  reg [1:0] pkind_r;
  reg [AW-1:0] paddr_r;
  reg [DW-1:0] pdata_r;
  reg [2:0] ps_r;
  reg [31:0] tmr_r;
  reg [31:0] tdur_r;
  reg poll_r;
  // Two-entry buffer between memory fetch and read shifter.
  reg [DW-1:0] buf_d [0:1];
  reg [1:0] buf_n_r;
  reg buf_wp_r, buf_rp_r;
  integer i;

  wire cs = cs_s_r[1];
  wire ck_rise = ck_s_r[1] & ~ck_s_r[2];
  wire di = di_s_r[1];
  wire cs_fall = ~cs_s_r[1] & cs_s_r[2];
  wire cs_rise = cs_s_r[1] & ~cs_s_r[2];
  wire pg = pg2_r;
  wire [1:0] opc = cmd_r[CMDW-1:CMDW-2];
  // The last address bit is still on the pin when the first fetch starts.
  wire [1:0] opc_last = cmd_r[CMDW-2:CMDW-3];
  wire [AW-1:0] adr_last = {cmd_r[AW-2:0], di};
  wire [AW-1:0] cadr = cmd_r[AW-1:0];
  wire buf_in_rdy = (buf_n_r != 2'h2);
  wire buf_out_vld = (buf_n_r != 2'h0);
  wire fill_req = (st_r == ST_CMD) && ck_rise && (cnt_r == CMDW - 1) &&
    (opc_last == `SEEPRM_OPC_READ);
  reg buf_push;
  reg buf_pop;

  // Two stages synchronise each pin; the third, on select and clock only, serves edge detection.
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      cs_s_r <= 3'h0;
      ck_s_r <= 3'h0;
      di_s_r <= 3'h0;
      pg1_r <= 1'b0;
      pg2_r <= 1'b0;
    end else begin
      cs_s_r <= {cs_s_r[1:0], CHIP_SEL};
      ck_s_r <= {ck_s_r[1:0], SER_CLK};
      di_s_r <= {di_s_r[1:0], SERIAL_IN};
      pg1_r <= POWER_GOOD;
      pg2_r <= pg1_r;
    end
  end

  // Word fetch into the buffer; the shifter drains it.
  // A slow master only delays the pop, so the fetch stays a word ahead.
  always @* begin
    buf_push = 1'b0;
    buf_pop = 1'b0;
    if (st_r == ST_READ && ck_rise && buf_out_vld && cs &&
        (cnt_r == 6'h0 || cnt_r == CNT_DW)) begin
      buf_pop = 1'b1;
    end
    if (buf_in_rdy && cs && (st_r == ST_READ || fill_req)) begin
      buf_push = 1'b1;
    end
  end

  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      buf_n_r <= 2'h0;
      buf_wp_r <= 1'b0;
      buf_rp_r <= 1'b0;
      addr_r <= {AW{1'b0}};
    end else if (!cs) begin
      buf_n_r <= 2'h0;
      buf_wp_r <= 1'b0;
      buf_rp_r <= 1'b0;
    end else begin
      if (buf_push) begin
        buf_d[buf_wp_r] <= mem[fill_req ? adr_last : addr_r];
        buf_wp_r <= ~buf_wp_r;
        addr_r <= (fill_req ? adr_last : addr_r) + 1'b1;
      end
      if (buf_pop) begin
        buf_rp_r <= ~buf_rp_r;
      end
      buf_n_r <= buf_n_r + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // Serial command front end.
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r <= ST_IDLE;
      cmd_r <= {CMDW{1'b0}};
      cnt_r <= 6'h0;
      sh_r <= {DW{1'b0}};
      wen_r <= 1'b0;
      pend_r <= 1'b0;
      pkind_r <= 2'h0;
      paddr_r <= {AW{1'b0}};
      pdata_r <= {DW{1'b0}};
      SERIAL_OUT <= 1'b0;
    end else if (!pg) begin
      wen_r <= 1'b0;
      st_r <= ST_IDLE;
      pend_r <= 1'b0;
    end else if (!cs) begin
      st_r <= ST_IDLE;
      cnt_r <= 6'h0;
      if (cs_fall && pend_r && ps_r == PS_IDLE) begin
        pend_r <= 1'b0;
      end
    end else begin
      case (st_r)
        ST_IDLE: begin
          // Status trails the timed cycle by one clock; polling is slower.
          if (poll_r) begin
            SERIAL_OUT <= (ps_r == PS_IDLE) ? `SEEPRM_READY_LEVEL :
              `SEEPRM_BUSY_LEVEL;
          end
          if (ck_rise && di && ps_r == PS_IDLE) begin
            st_r <= ST_CMD;
            cnt_r <= 6'h0;
            pend_r <= 1'b0;
          end
        end
        ST_CMD: begin
          if (ck_rise) begin
            cmd_r <= {cmd_r[CMDW-2:0], di};
            cnt_r <= cnt_r + 6'h1;
            if (cnt_r == CMDW - 1) begin
              cnt_r <= 6'h0;
              st_r <= ST_DONE;
              case (cmd_r[CMDW-2:CMDW-3])
                `SEEPRM_OPC_READ: begin
                  st_r <= ST_READ;
                  cnt_r <= CNT_DW;
                  SERIAL_OUT <= 1'b0;
                end
                `SEEPRM_OPC_WRITE: st_r <= ST_DATA;
                `SEEPRM_OPC_ERASE: begin
                  pend_r <= wen_r;
                  pkind_r <= 2'h0;
                  paddr_r <= {cmd_r[AW-2:0], di};
                end
                default: begin
                  case (cmd_r[AW-2:AW-3])
                    `SEEPRM_SUB_ENABLE: wen_r <= 1'b1;
                    `SEEPRM_SUB_DISABLE: wen_r <= 1'b0;
                    `SEEPRM_SUB_ERASE_ALL: begin
                      pend_r <= wen_r;
                      pkind_r <= 2'h2;
                    end
                    default: st_r <= ST_DATA;
                  endcase
                end
              endcase
            end
          end
        end
        ST_DATA: begin
          if (ck_rise) begin
            sh_r <= {sh_r[DW-2:0], di};
            cnt_r <= cnt_r + 6'h1;
            if (cnt_r == DW - 1) begin
              st_r <= ST_DONE;
              pdata_r <= {sh_r[DW-2:0], di};
              paddr_r <= cadr;
              pend_r <= wen_r;
              pkind_r <= (opc == `SEEPRM_OPC_WRITE) ? 2'h1 : 2'h3;
            end
          end
        end
        ST_READ: begin
          if (ck_rise) begin
            // A load drops the top bit from the shifter; it is already out.
            if (cnt_r == 6'h0 || cnt_r == CNT_DW) begin
              sh_r <= {buf_d[buf_rp_r][DW-2:0], 1'b0};
              SERIAL_OUT <= buf_d[buf_rp_r][DW-1];
              cnt_r <= CNT_LAST;
            end else begin
              SERIAL_OUT <= sh_r[DW-1];
              sh_r <= {sh_r[DW-2:0], 1'b0};
              cnt_r <= cnt_r - 6'h1;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Self-timed programming runs on MCLK; it starts on a select fall and then ignores the serial pins.
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ps_r <= PS_IDLE;
      tmr_r <= 32'h0;
      tdur_r <= 32'h0;
      PROG_BUSY <= 1'b0;
    end else begin
      case (ps_r)
        PS_IDLE: begin
          if (cs_fall && pend_r && pg && cs_s_r[2]) begin
            ps_r <= PS_ERASE;
            tmr_r <= 32'h0;
            PROG_BUSY <= 1'b1;
            tdur_r <= (pkind_r == 2'h2) ? T_ERASE_ALL_CMD_CYC :
              (pkind_r == 2'h3) ? T_WRITE_ALL_CMD_CYC : T_WORD_CYC;
          end
        end
        PS_ERASE: begin
          if (pkind_r[1]) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
              mem[i] <= {DW{`SEEPRM_ERASED_BIT}};
            end
          end else begin
            mem[paddr_r] <= {DW{`SEEPRM_ERASED_BIT}};
          end
          ps_r <= PS_PROG;
        end
        PS_PROG: begin
          tmr_r <= tmr_r + 32'h1;
          // Losing power mid-cycle leaves the word erased but not written.
          if (!pg) begin
            ps_r <= PS_IDLE;
            PROG_BUSY <= 1'b0;
          end else if (tmr_r >= tdur_r - 32'h1) begin
            ps_r <= PS_IDLE;
            PROG_BUSY <= 1'b0;
            if (pkind_r == 2'h1) begin
              mem[paddr_r] <= pdata_r;
            end else if (pkind_r == 2'h3) begin
              for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= pdata_r;
              end
            end
          end
        end
        default: ps_r <= PS_IDLE;
      endcase
    end
  end

  // Output enable and status polling.
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      poll_r <= 1'b0;
      SERIAL_OUT_OE <= 1'b0;
    end else begin
      if (cs_fall) begin
        poll_r <= (ps_r != PS_IDLE) || (pend_r && pg);
      end else if (cs && st_r == ST_CMD) begin
        poll_r <= 1'b0;
      end
      if (!cs) begin
        SERIAL_OUT_OE <= 1'b0;
      end else if (st_r == ST_READ) begin
        SERIAL_OUT_OE <= 1'b1;
      end else if (poll_r && st_r == ST_IDLE && !cs_rise) begin
        SERIAL_OUT_OE <= 1'b1;
      end else begin
        SERIAL_OUT_OE <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// *** bench/seeprm_engine_chk.sv ***
// Purpose: Port checks for the serial memory command engine.
// Assumes: Serial pins are sampled on MCLK.
// Notes: Busy bounds carry a few cycles of slack for pin synchronisers.
`default_nettype none
module seeprm_chk #(
  parameter T_WORD_CYC = 50,
  parameter T_WRITE_ALL_CMD_CYC = 50
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic POWER_GOOD,
  input wire logic CHIP_SEL,
  input wire logic SER_CLK,
  input wire logic SERIAL_OUT,
  input wire logic SERIAL_OUT_OE,
  input wire logic PROG_BUSY
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  logic [31:0] busy_cnt_r;
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) busy_cnt_r <= 32'h0000_0000;
    else if (PROG_BUSY) busy_cnt_r <= busy_cnt_r + 32'h0000_0001;
    else busy_cnt_r <= 32'h0000_0000;
  end
  sequence sel_fall;
    CHIP_SEL ##1 !CHIP_SEL;
  endsequence
  sequence clk_quiet;
    (SERIAL_OUT_OE && !SER_CLK && !PROG_BUSY)[*7];
  endsequence
  chk_oe_release: assert property (
    sel_fall |-> ##[1:6] !SERIAL_OUT_OE) else $error("Output kept on.");
  chk_out_on_rise: assert property (
    clk_quiet |=> $stable(SERIAL_OUT) || !SERIAL_OUT_OE)
    else $error("Output moved without a serial clock rise.");
  chk_sel_starts: assert property (
    $rose(PROG_BUSY) |-> !CHIP_SEL) else $error("Cycle began while selected.");
  chk_power_gate: assert property (
    $rose(PROG_BUSY) |-> $past(POWER_GOOD, 3))
    else $error("Cycle without power.");
  chk_no_clocks: assert property (
    $rose(PROG_BUSY) |-> PROG_BUSY[*8]) else $error("Cycle ended early.");
  chk_busy_max: assert property (
    PROG_BUSY |-> busy_cnt_r <= T_WRITE_ALL_CMD_CYC + 4) else $error("Cycle too long.");
  chk_busy_min: assert property (
    $fell(PROG_BUSY) |-> busy_cnt_r + 2 >= T_WORD_CYC)
    else $error("Busy dropped before the timed count.");
  chk_oe_needs_sel: assert property (
    $rose(SERIAL_OUT_OE) |-> CHIP_SEL) else $error("Output on while idle.");
  chk_idle_quiet: assert property (
    !CHIP_SEL[*6] |-> !SERIAL_OUT_OE)
    else $error("Output on while deselected.");
  chk_status_busy: assert property (
    SERIAL_OUT_OE && PROG_BUSY |-> SERIAL_OUT == 1'b0)
    else $error("Ready shown during a timed cycle.");
  chk_status_ready: assert property (
    $fell(PROG_BUSY) && SERIAL_OUT_OE |=> SERIAL_OUT || !SERIAL_OUT_OE)
    else $error("Busy shown after the timed cycle.");
endmodule
bind seeprm_engine seeprm_chk #(.T_WORD_CYC(T_WORD_CYC),
  .T_WRITE_ALL_CMD_CYC(T_WRITE_ALL_CMD_CYC)) u_chk (.MCLK(MCLK), .RESETN(RESETN),
  .POWER_GOOD(POWER_GOOD), .CHIP_SEL(CHIP_SEL), .SER_CLK(SER_CLK),
  .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE(SERIAL_OUT_OE),
  .PROG_BUSY(PROG_BUSY));
`default_nettype wire

// *** bench/seeprm_master.sv ***
// Purpose: Behavioural serial bus master facing the command engine.
// Assumes: Pins change just after an MCLK edge.
// Notes: The serial clock runs at 160 ns inside frames when gap is 0 and idles low.
`default_nettype none
module seeprm_master (
  input wire logic mclk,
  output logic cs,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rdata;
  int gap;
  initial begin
    cs = 1'b0;
    sclk = 1'b0;
    sdi = 1'b0;
    rdata = 32'h0000_0000;
    gap = 0;
  end
  // Data is set up ahead of the rise; gap stretches the low time.
  task automatic shift(input int n, input logic [31:0] v);
    for (int i = n - 1; i >= 0; i--) begin
      sdi <= v[i];
      repeat (2) @(posedge mclk);
      sclk <= 1'b1;
      repeat (4) @(posedge mclk);
      sclk <= 1'b0;
      repeat (2 + gap) @(posedge mclk);
      rdata = {rdata[30:0], sdo_oe ? sdo : ~rdata[0]};
    end
  endtask
  task automatic sel();
    cs <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  task automatic frame(input int n, input logic [31:0] v);
    sel();
    shift(n, v);
  endtask
  // Low for 320 ns, so a later rise is a legal status poll.
  task automatic drop();
    cs <= 1'b0;
    sdi <= ~sdi;
    repeat (16) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// *** bench/seeprm_engine_test.sv ***
// Purpose: Self-checking bench for the serial memory command engine.
// Assumes: Timed cycles shortened to 50 clocks; word-wide organisation.
// Notes: Ready and busy are read on the data output while status is shown.
`include "seeprm_regs.vh"
`default_nettype none
module seeprm_engine_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, resetn, pgood;
  wire cs, sclk, sdi, sdo, sdo_oe, busy;
  int checked = 0;
  int miscompares = 0;
  seeprm_engine #(.T_WORD_CYC(50), .T_ERASE_ALL_CMD_CYC(50), .T_WRITE_ALL_CMD_CYC(50)) uut (
    .MCLK(mclk), .RESETN(resetn), .POWER_GOOD(pgood), .CHIP_SEL(cs),
    .SER_CLK(sclk), .SERIAL_IN(sdi), .SERIAL_OUT(sdo),
    .SERIAL_OUT_OE(sdo_oe), .PROG_BUSY(busy));
  seeprm_master mst (.mclk(mclk), .cs(cs), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe));
  function automatic logic [8:0] op(input logic [1:0] c, input logic [5:0] a);
    return {1'b1, c, a};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Sends one frame; with go set it is then polled until ready.
  task automatic run(input int n, input logic [31:0] v, input logic go);
    int i;
    mst.frame(n, v);
    mst.drop();
    check(busy, go);
    if (go) begin
      mst.sel();
      repeat (6) @(posedge mclk);
      check(sdo_oe, 1'b1);
      check(sdo, `SEEPRM_BUSY_LEVEL);
      for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge mclk);
      check(busy, 1'b0);
      if (i == 400) end_of_test();
      repeat (2) @(posedge mclk);
      check(sdo, `SEEPRM_READY_LEVEL);
      mst.drop();
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e0, e1);
    mst.frame(9, op(`SEEPRM_OPC_READ, a));
    check({sdo_oe, mst.rdata[0]}, 2'b10);
    mst.shift(16, 0);
    check(mst.rdata[15:0], e0);
    mst.shift(16, 0);
    check(mst.rdata[15:0], e1);
    mst.drop();
  endtask
  function automatic logic [8:0] sp(input logic [1:0] s);
    return op(`SEEPRM_OPC_SPECIAL, {s, 4'h0});
  endfunction
  task automatic t_locked();
    mst.frame(12, 32'h0000_0000);
    check(sdo_oe, 1'b0);
    mst.drop();
    run(25, {op(`SEEPRM_OPC_WRITE, 6'h05), 16'h0000}, 1'b0);
    $display("test locked done");
  endtask
  task automatic t_erase();
    run(9, sp(`SEEPRM_SUB_ENABLE), 1'b0);
    run(9, sp(`SEEPRM_SUB_ERASE_ALL), 1'b1);
    rd(6'h00, 16'hFFFF, 16'hFFFF);
    $display("test erase done");
  endtask
  task automatic t_write();
    mst.gap = 12;
    run(25, {op(`SEEPRM_OPC_WRITE, 6'h01), 16'hA5C3}, 1'b1);
    run(25, {op(`SEEPRM_OPC_WRITE, 6'h02), 16'h0001}, 1'b1);
    mst.gap = 0;
    rd(6'h01, 16'hA5C3, 16'h0001);
    run(9, op(`SEEPRM_OPC_ERASE, 6'h01), 1'b1);
    rd(6'h00, 16'hFFFF, 16'hFFFF);
    $display("test write done");
  endtask
  task automatic t_write_all_cmd();
    run(25, {sp(`SEEPRM_SUB_WRITE_ALL), 16'h1234}, 1'b1);
    mst.gap = 12;
    rd(6'h3E, 16'h1234, 16'h1234);
    mst.gap = 0;
    run(9, sp(`SEEPRM_SUB_DISABLE), 1'b0);
    run(25, {op(`SEEPRM_OPC_WRITE, 6'h03), 16'h0000}, 1'b0);
    run(25, {sp(`SEEPRM_SUB_WRITE_ALL), 16'h0000}, 1'b0);
    rd(6'h03, 16'h1234, 16'h1234);
    $display("test write all done");
  endtask
  task automatic t_power();
    run(9, sp(`SEEPRM_SUB_ENABLE), 1'b0);
    pgood <= 1'b0;
    repeat (4) @(posedge mclk);
    run(25, {op(`SEEPRM_OPC_WRITE, 6'h04), 16'h0000}, 1'b0);
    pgood <= 1'b1;
    repeat (4) @(posedge mclk);
    run(25, {op(`SEEPRM_OPC_WRITE, 6'h04), 16'h0000}, 1'b0);
    $display("test power done");
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    resetn = 1'b0;
    pgood = 1'b1;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    t_locked();
    t_erase();
    t_write();
    t_write_all_cmd();
    t_power();
    end_of_test();
  end
endmodule
`default_nettype wire
